// file: logic/pmm_pkg.sv
package pmm_pkg;
    // ----------------------------------------
    // clock and wake timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 25000;
    localparam int unsigned WAKE_IDLE_NS = 14000;
    localparam int unsigned WAKE_STBY_NS = 151000;
    localparam int unsigned WAKE_SHDN_NS = 1015000;
    localparam int unsigned WAKE_IDLE_CYC =
        (WAKE_IDLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned WAKE_STBY_CYC =
        (WAKE_STBY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned WAKE_SHDN_CYC =
        (WAKE_SHDN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 16;

    // ----------------------------------------
    // sizes, register map, fields
    // ----------------------------------------
    localparam int NGPIO = 31;
    localparam int NSRAM = 4;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RETEN = 8'h04;
    localparam logic [7:0] OFS_CLKSEL = 8'h08;
    localparam logic [7:0] OFS_WAKEMASK = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CLKSEL_FAST_BIT = 0;
    localparam int CLKSEL_SLOW_BIT = 1;
    localparam int STATUS_CAUSE_LSB = 0;
    localparam int STATUS_STATE_LSB = 4;
    localparam logic [3:0] RETEN_RST = 4'hf;
    localparam logic [1:0] CLKSEL_RST = 2'h0;
    localparam logic [30:0] WAKEMASK_RST = 31'h0;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        MODE_ACTIVE = 3'h0,
        MODE_IDLE = 3'h1,
        MODE_STBY = 3'h2,
        MODE_SHDN = 3'h3,
        MODE_HOLD = 3'h4
    } pmm_mode_t;

    typedef enum logic [1:0] {
        CAUSE_POR = 2'h1,
        CAUSE_PIN_RST = 2'h2,
        CAUSE_SHDN_WAKE = 2'h3
    } pmm_cause_t;

    typedef enum logic [1:0] {
        BOD_OFF = 2'h0,
        BOD_ON = 2'h1,
        BOD_DUTY = 2'h2
    } pmm_bod_t;

    typedef enum logic [5:0] {
        ST_ACTIVE = 6'h01,
        ST_IDLE = 6'h02,
        ST_STBY = 6'h04,
        ST_SHDN = 6'h08,
        ST_HOLD = 6'h10,
        ST_WAKE = 6'h20
    } pmm_state_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic mem_clk_en;
        logic flash_on;
        logic [3:0] sram_on;
        logic radio_on;
        logic periph_on;
        logic periph_clk_en;
        logic fast_clk_en;
        logic slow_clk_en;
        logic fast_src;
        logic slow_src;
        logic aon_on;
        pmm_bod_t brownout_detector;
        logic por_en;
        logic io_latch;
        logic retain;
        logic sys_rst_n;
    } pmm_pwr_t;
endpackage

// file: logic/pmm_power_mode_manager.sv
`timescale 1ns/1ps
module pmm_power_mode_manager #(
    parameter int unsigned WAKE_STBY_CYC = pmm_pkg::WAKE_STBY_CYC,
    parameter int unsigned WAKE_SHDN_CYC = pmm_pkg::WAKE_SHDN_CYC
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic irq_in,
    input wire logic rtc_wake_in,
    input wire logic reset_pin_n_in,
    input wire logic [30:0] io_in,
    output pmm_pkg::pmm_pwr_t pwr_out,
    output logic [30:0] io_hold_out
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [30:0] io_s1_r, io_s2_r, io_s3_r;
    logic rtc_s1_r, rtc_s2_r, rtc_s3_r;
    logic rp_s1_r, rp_s2_r, rp_s3_r;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            io_s1_r <= 31'h0;
            io_s2_r <= 31'h0;
            io_s3_r <= 31'h0;
            rtc_s1_r <= 1'h0;
            rtc_s2_r <= 1'h0;
            rtc_s3_r <= 1'h0;
            rp_s1_r <= 1'h1;
            rp_s2_r <= 1'h1;
            rp_s3_r <= 1'h1;
        end else begin
            io_s1_r <= io_in;
            io_s2_r <= io_s1_r;
            io_s3_r <= io_s2_r;
            rtc_s1_r <= rtc_wake_in;
            rtc_s2_r <= rtc_s1_r;
            rtc_s3_r <= rtc_s2_r;
            rp_s1_r <= reset_pin_n_in;
            rp_s2_r <= rp_s1_r;
            rp_s3_r <= rp_s2_r;
        end
    end

    // ----------------------------------------
    // events and decode
    // ----------------------------------------
    pmm_pkg::pmm_state_t state_r;
    logic rst_wake_r;
    logic [pmm_pkg::CNT_W-1:0] wake_cnt_r;
    logic [3:0] reten_r;
    logic [1:0] clksel_r;
    logic [30:0] wakemask_r;
    pmm_pkg::pmm_cause_t cause_r;
    logic pin_edge, rtc_ev, rstpin_ev, ctrl_wr, enter_latch;
    pmm_pkg::pmm_mode_t req_mode;

    // any level change on a wake-enabled pin
    assign pin_edge = |((io_s2_r ^ io_s3_r) & wakemask_r);
    assign rtc_ev = rtc_s2_r & ~rtc_s3_r;
    assign rstpin_ev = ~rp_s2_r & rp_s3_r;
    assign ctrl_wr = reg_wr_in && (reg_addr_in == pmm_pkg::OFS_CTRL);
    assign req_mode = pmm_pkg::pmm_mode_t'(
        reg_wdata_in[pmm_pkg::CTRL_MODE_LSB +: 3]);
    assign enter_latch = ctrl_wr && (state_r == pmm_pkg::ST_ACTIVE)
        && (req_mode == pmm_pkg::MODE_STBY
        || req_mode == pmm_pkg::MODE_SHDN
        || req_mode == pmm_pkg::MODE_HOLD);

    function automatic logic [pmm_pkg::CNT_W-1:0] wake_len(
        input pmm_pkg::pmm_state_t st
    );
        logic [pmm_pkg::CNT_W-1:0] n;
        n = pmm_pkg::CNT_W'(WAKE_SHDN_CYC);
        if (st == pmm_pkg::ST_IDLE) begin
            n = pmm_pkg::CNT_W'(pmm_pkg::WAKE_IDLE_CYC);
        end else if (st == pmm_pkg::ST_STBY) begin
            n = pmm_pkg::CNT_W'(WAKE_STBY_CYC);
        end
        return n;
    endfunction

    function automatic logic [2:0] state_code(
        input pmm_pkg::pmm_state_t st
    );
        logic [2:0] c;
        c = 3'h5;
        unique case (st)
            pmm_pkg::ST_ACTIVE: c = pmm_pkg::MODE_ACTIVE;
            pmm_pkg::ST_IDLE: c = pmm_pkg::MODE_IDLE;
            pmm_pkg::ST_STBY: c = pmm_pkg::MODE_STBY;
            pmm_pkg::ST_SHDN: c = pmm_pkg::MODE_SHDN;
            pmm_pkg::ST_HOLD: c = pmm_pkg::MODE_HOLD;
            pmm_pkg::ST_WAKE: c = 3'h5;
        endcase
        return c;
    endfunction

    // ----------------------------------------
    // mode sequencer
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r <= pmm_pkg::ST_ACTIVE;
            wake_cnt_r <= 16'h0;
            rst_wake_r <= 1'h0;
        end else if (rstpin_ev) begin
            // reset pin wakes from every mode
            state_r <= pmm_pkg::ST_WAKE;
            wake_cnt_r <= pmm_pkg::CNT_W'(WAKE_SHDN_CYC);
            rst_wake_r <= 1'h1;
        end else begin
            unique case (state_r)
                pmm_pkg::ST_ACTIVE: begin
                    if (ctrl_wr) begin
                        unique case (req_mode)
                            pmm_pkg::MODE_IDLE: state_r <= pmm_pkg::ST_IDLE;
                            pmm_pkg::MODE_STBY: state_r <= pmm_pkg::ST_STBY;
                            pmm_pkg::MODE_SHDN: state_r <= pmm_pkg::ST_SHDN;
                            pmm_pkg::MODE_HOLD: state_r <= pmm_pkg::ST_HOLD;
                            default: state_r <= pmm_pkg::ST_ACTIVE;
                        endcase
                    end
                end
                pmm_pkg::ST_IDLE: begin
                    // any interrupt returns idle to active
                    if (irq_in || rtc_ev || pin_edge) begin
                        state_r <= pmm_pkg::ST_WAKE;
                        wake_cnt_r <= wake_len(state_r);
                        rst_wake_r <= 1'h0;
                    end
                end
                pmm_pkg::ST_STBY: begin
                    // only pin or timer leaves standby
                    if (rtc_ev || pin_edge) begin
                        state_r <= pmm_pkg::ST_WAKE;
                        wake_cnt_r <= wake_len(state_r);
                        rst_wake_r <= 1'h0;
                    end
                end
                pmm_pkg::ST_SHDN: begin
                    if (pin_edge) begin
                        state_r <= pmm_pkg::ST_WAKE;
                        wake_cnt_r <= wake_len(state_r);
                        rst_wake_r <= 1'h1;
                    end
                end
                pmm_pkg::ST_HOLD: begin
                    // hold leaves only through the reset pin
                    state_r <= pmm_pkg::ST_HOLD;
                end
                pmm_pkg::ST_WAKE: begin
                    if (wake_cnt_r <= 16'h1) begin
                        state_r <= pmm_pkg::ST_ACTIVE;
                        rst_wake_r <= 1'h0;
                    end else begin
                        wake_cnt_r <= wake_cnt_r - 16'h1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // reset cause
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cause_r <= pmm_pkg::CAUSE_POR;
        end else if (rstpin_ev) begin
            cause_r <= pmm_pkg::CAUSE_PIN_RST;
        end else if (state_r == pmm_pkg::ST_SHDN && pin_edge) begin
            cause_r <= pmm_pkg::CAUSE_SHDN_WAKE;
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reten_r <= pmm_pkg::RETEN_RST;
            clksel_r <= pmm_pkg::CLKSEL_RST;
            wakemask_r <= pmm_pkg::WAKEMASK_RST;
        end else if (state_r == pmm_pkg::ST_WAKE && rst_wake_r) begin
            reten_r <= pmm_pkg::RETEN_RST;
            clksel_r <= pmm_pkg::CLKSEL_RST;
            wakemask_r <= pmm_pkg::WAKEMASK_RST;
        end else if (reg_wr_in && state_r == pmm_pkg::ST_ACTIVE) begin
            // only the running cpu can write; other writes are dropped
            unique case (reg_addr_in)
                // one retention enable per sram block
                pmm_pkg::OFS_RETEN: reten_r <= reg_wdata_in[3:0];
                pmm_pkg::OFS_CLKSEL: clksel_r <= reg_wdata_in[1:0];
                pmm_pkg::OFS_WAKEMASK: wakemask_r <= reg_wdata_in[30:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 32'h0;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                pmm_pkg::OFS_RETEN: reg_rdata_out <= {28'h0, reten_r};
                pmm_pkg::OFS_CLKSEL: reg_rdata_out <= {30'h0, clksel_r};
                pmm_pkg::OFS_WAKEMASK: reg_rdata_out <= {1'h0, wakemask_r};
                pmm_pkg::OFS_STATUS: begin
                    reg_rdata_out <= {25'h0, state_code(state_r),
                        2'h0, cause_r};
                end
                default: reg_rdata_out <= 32'h0;
            endcase
        end else begin
            reg_rdata_out <= 32'h0;
        end
    end

    // ----------------------------------------
    // io latch
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            io_hold_out <= 31'h0;
        end else if (enter_latch) begin
            io_hold_out <= io_s2_r;
        end
    end

    // ----------------------------------------
    // pad latch tracking
    // ----------------------------------------
    // idle never captures the pads, so its wake must not show stale levels
    logic pads_hold_mode_r;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pads_hold_mode_r <= 1'h0;
        end else if (enter_latch) begin
            pads_hold_mode_r <= 1'h1;
        end else if (state_r == pmm_pkg::ST_ACTIVE) begin
            pads_hold_mode_r <= 1'h0;
        end
    end

    // ----------------------------------------
    // power and clock gating
    // ----------------------------------------
    // registered from state, so gates lag the state by one cycle
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pwr_out <= '0;
        end else begin
            pwr_out <= '0;
            pwr_out.fast_src <= clksel_r[pmm_pkg::CLKSEL_FAST_BIT];
            pwr_out.slow_src <= clksel_r[pmm_pkg::CLKSEL_SLOW_BIT];
            pwr_out.sys_rst_n <= 1'h1;
            unique case (state_r)
                pmm_pkg::ST_ACTIVE, pmm_pkg::ST_IDLE: begin
                    // idle stops cpu and memory clocks only
                    pwr_out.cpu_clk_en <= (state_r == pmm_pkg::ST_ACTIVE);
                    pwr_out.mem_clk_en <= (state_r == pmm_pkg::ST_ACTIVE);
                    pwr_out.flash_on <= 1'h1;
                    pwr_out.sram_on <= 4'hf;
                    pwr_out.radio_on <= 1'h1;
                    pwr_out.periph_on <= 1'h1;
                    pwr_out.periph_clk_en <= 1'h1;
                    pwr_out.fast_clk_en <= 1'h1;
                    pwr_out.slow_clk_en <= 1'h1;
                    pwr_out.aon_on <= 1'h1;
                    // brown-out active in active and idle
                    pwr_out.brownout_detector <= pmm_pkg::BOD_ON;
                    pwr_out.por_en <= 1'h1;
                end
                pmm_pkg::ST_STBY: begin
                    pwr_out.sram_on <= reten_r;
                    // slow clock runs, fast clock stopped
                    pwr_out.slow_clk_en <= 1'h1;
                    pwr_out.aon_on <= 1'h1;
                    pwr_out.brownout_detector <= pmm_pkg::BOD_DUTY;
                    pwr_out.por_en <= 1'h1;
                    pwr_out.io_latch <= 1'h1;
                    pwr_out.retain <= 1'h1;
                end
                pmm_pkg::ST_SHDN: begin
                    pwr_out.por_en <= 1'h1;
                    pwr_out.io_latch <= 1'h1;
                end
                pmm_pkg::ST_HOLD: begin
                    pwr_out.io_latch <= 1'h1;
                end
                pmm_pkg::ST_WAKE: begin
                    pwr_out.flash_on <= 1'h1;
                    pwr_out.sram_on <= 4'hf;
                    pwr_out.fast_clk_en <= 1'h1;
                    pwr_out.slow_clk_en <= 1'h1;
                    pwr_out.aon_on <= 1'h1;
                    pwr_out.brownout_detector <= pmm_pkg::BOD_ON;
                    pwr_out.por_en <= 1'h1;
                    pwr_out.io_latch <= pads_hold_mode_r;
                    pwr_out.retain <= ~rst_wake_r;
                    // reset-type wake holds the system in reset
                    pwr_out.sys_rst_n <= ~rst_wake_r;
                end
            endcase
        end
    end

endmodule

// file: test/pmm_chk.sv
`timescale 1ns/1ps
module pmm_chk #(
    parameter int unsigned WAKE_STBY_CYC = 20,
    parameter int unsigned WAKE_SHDN_CYC = 40
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic reset_pin_n_in,
    input wire pmm_pkg::pmm_pwr_t pwr_out,
    input wire logic [30:0] io_hold_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);

    // ----------------------------------------
    // mode sequences
    // ----------------------------------------
    sequence s_idle_req;
        reg_wr_in && reg_addr_in == pmm_pkg::OFS_CTRL
            && reg_wdata_in[2:0] == 3'h1 && pwr_out.cpu_clk_en
            && !$past(reg_wr_in && reg_addr_in == pmm_pkg::OFS_CTRL);
    endsequence
    // reset pin high long enough that no pin wake is in flight
    sequence s_pin_quiet;
        reset_pin_n_in && $past(reset_pin_n_in)
            && $past(reset_pin_n_in, 2) && $past(reset_pin_n_in, 3);
    endsequence
    sequence s_idle_shown;
        !pwr_out.cpu_clk_en && !pwr_out.mem_clk_en && pwr_out.periph_clk_en;
    endsequence
    // hold is the only latched mode with the power-on detector off
    sequence s_hold;
        pwr_out.io_latch && !pwr_out.por_en;
    endsequence

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_idle_entry: assert property (
        s_idle_req ##0 s_pin_quiet |-> ##2 s_idle_shown)
        else $error("idle entry gating wrong");
    a_hold_stays: assert property (
        s_hold ##0 s_pin_quiet |=> s_hold)
        else $error("hold left without reset pin");
    a_latch_stable: assert property (
        pwr_out.io_latch && $past(pwr_out.io_latch) |-> $stable(io_hold_out))
        else $error("latched pins moved");
    a_stby_clocks: assert property (
        pwr_out.brownout_detector == pmm_pkg::BOD_DUTY
        |-> !pwr_out.fast_clk_en && pwr_out.slow_clk_en && pwr_out.aon_on)
        else $error("standby clocks wrong");
    a_active_bod: assert property (
        pwr_out.cpu_clk_en
        |-> pwr_out.brownout_detector == pmm_pkg::BOD_ON && pwr_out.fast_clk_en)
        else $error("active detector or clock wrong");
    a_shdn_off: assert property (
        !pwr_out.aon_on |-> pwr_out.sram_on == 4'h0 && !pwr_out.flash_on)
        else $error("memory powered with always-on off");
    a_rdata_zero: assert property (
        !$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data outside read cycle");
    a_duty_no_rst: assert property (
        pwr_out.brownout_detector == pmm_pkg::BOD_DUTY ##0 s_pin_quiet
        |=> pwr_out.sys_rst_n)
        else $error("standby wake reset the system");
endmodule

bind pmm_power_mode_manager pmm_chk #(
    .WAKE_STBY_CYC(WAKE_STBY_CYC),
    .WAKE_SHDN_CYC(WAKE_SHDN_CYC)
) u_chk (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .reset_pin_n_in(reset_pin_n_in),
    .pwr_out(pwr_out),
    .io_hold_out(io_hold_out)
);

// file: test/pmm_testbench.sv
`timescale 1ns/1ps
module testbench;
    logic mclk_in = 1'h0;
    logic nrst_in = 1'h0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'h0;
    logic reg_rd_in = 1'h0;
    logic [31:0] reg_rdata_out;
    logic irq_in = 1'h0;
    logic rtc_wake_in = 1'h0;
    logic reset_pin_n_in = 1'h1;
    logic [30:0] io_in = 31'h0;
    pmm_pkg::pmm_pwr_t pwr_out;
    logic [30:0] io_hold_out;
    int errors = 0;
    int num_checks = 0;
    int seed = 13816;
    int n;
    logic [3:0] reten;
    logic [1:0] clksel;
    logic [30:0] io_snap;

    always #12.5 mclk_in = ~mclk_in;

    // short wake counts keep the run brief
    pmm_power_mode_manager #(.WAKE_STBY_CYC(20), .WAKE_SHDN_CYC(40)) uut (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .irq_in(irq_in),
        .rtc_wake_in(rtc_wake_in),
        .reset_pin_n_in(reset_pin_n_in),
        .io_in(io_in),
        .pwr_out(pwr_out),
        .io_hold_out(io_hold_out)
    );

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    // status word as software should see it
    function automatic logic [31:0] status_word(input logic [2:0] md,
                                                input logic [1:0] c);
        return (32'(md) << pmm_pkg::STATUS_STATE_LSB)
            | (32'(c) << pmm_pkg::STATUS_CAUSE_LSB);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_wr_in <= 1'h1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge mclk_in);
        reg_wr_in <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        @(posedge mclk_in);
        reg_rd_in <= 1'h1;
        reg_addr_in <= a;
        @(posedge mclk_in);
        reg_rd_in <= 1'h0;
        #1;
        chk(nm, reg_rdata_out, e);
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge mclk_in);
        #1;
    endtask

    // counts edges from the event edge until the cpu clock is back;
    // ex is the expected {sys_rst_n, retain, io_latch} during the wake
    task automatic wake_time(input int lo, input int hi,
                             input logic [2:0] ex, input string nm);
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
            irq_in <= 1'h0;
            rtc_wake_in <= 1'h0;
            if (n == 3) begin
                reset_pin_n_in <= 1'h1;
            end
            #1;
            if (n == 6) begin
                chk({nm, "_rst"}, {29'h0, pwr_out.sys_rst_n, pwr_out.retain,
                    pwr_out.io_latch}, {29'h0, ex});
            end
        end while (pwr_out.cpu_clk_en !== 1'h1 && n < 2000);
        chk(nm, {31'h0, n >= lo && n <= hi}, 32'h1);
    endtask

    task automatic end_sim;
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge mclk_in);
        nrst_in <= 1'h1;
        @(posedge mclk_in);
        rd(pmm_pkg::OFS_STATUS, status_word(3'h0, 2'h1), "status_por");
        rd(pmm_pkg::OFS_RETEN, 32'hf, "reten_rst");
        rd(8'h14, 32'h0, "unmapped");
        wr(pmm_pkg::OFS_STATUS, 32'h2);
        rd(pmm_pkg::OFS_STATUS, status_word(3'h0, 2'h1), "status_ro");
        // an undefined mode code must leave the cpu running
        wr(pmm_pkg::OFS_CTRL, 32'h5);
        settle(2);
        chk("bad_mode", {31'h0, pwr_out.cpu_clk_en}, 32'h1);
        for (int i = 0; i < 3; i++) begin
            reten = 4'($random(seed));
            clksel = 2'($random(seed));
            @(posedge mclk_in);
            io_in <= 31'($random(seed));
            wr(pmm_pkg::OFS_RETEN, {28'h0, reten});
            wr(pmm_pkg::OFS_CLKSEL, {30'h0, clksel});
            settle(2);
            chk("clk_src", {30'h0, pwr_out.fast_src, pwr_out.slow_src},
                {30'h0, clksel[0], clksel[1]});
            io_snap = io_in;
            wr(pmm_pkg::OFS_CTRL, 32'h2);
            settle(2);
            chk("sram_ret", {28'h0, pwr_out.sram_on}, {28'h0, reten});
            chk("io_latch", {1'h0, io_hold_out}, {1'h0, io_snap});
            chk("stby_off", {29'h0, pwr_out.radio_on, pwr_out.periph_on,
                pwr_out.retain}, 32'h1);
            @(posedge mclk_in);
            io_in <= ~io_in;
            irq_in <= 1'h1;
            wr(pmm_pkg::OFS_RETEN, 32'h0);
            irq_in <= 1'h0;
            settle(4);
            chk("io_hold_mode", {1'h0, io_hold_out}, {1'h0, io_snap});
            chk("stby_stay", {30'h0, pwr_out.brownout_detector}, 32'h2);
            @(posedge mclk_in);
            rtc_wake_in <= 1'h1;
            wake_time(21, 28, 3'h7, "stby_wake");
            rd(pmm_pkg::OFS_RETEN, {28'h0, reten}, "reten_kept");
        end
        wr(pmm_pkg::OFS_CTRL, 32'h1);
        settle(2);
        chk("idle_gate", {29'h0, pwr_out.cpu_clk_en, pwr_out.mem_clk_en,
            pwr_out.periph_clk_en}, 32'h1);
        chk("idle_on", {30'h0, pwr_out.periph_on,
            pwr_out.flash_on}, 32'h3);
        @(posedge mclk_in);
        irq_in <= 1'h1;
        wake_time(562, 562, 3'h6, "idle_wake");
        @(posedge mclk_in);
        io_in <= 31'h0;
        wr(pmm_pkg::OFS_WAKEMASK, 32'h20);
        wr(pmm_pkg::OFS_CTRL, 32'h3);
        settle(2);
        chk("shdn_pwr", {27'h0, pwr_out.aon_on, pwr_out.sram_on}, 32'h0);
        chk("shdn_det", {29'h0, pwr_out.brownout_detector,
            pwr_out.por_en}, 32'h1);
        chk("shdn_io", {1'h0, io_hold_out}, 32'h0);
        // rtc and a pin outside the wake mask must not wake shutdown
        @(posedge mclk_in);
        rtc_wake_in <= 1'h1;
        io_in[3] <= 1'h1;
        @(posedge mclk_in);
        rtc_wake_in <= 1'h0;
        settle(8);
        chk("shdn_stay", {31'h0, pwr_out.aon_on}, 32'h0);
        @(posedge mclk_in);
        io_in[5] <= 1'h1;
        wake_time(41, 48, 3'h1, "shdn_wake");
        rd(pmm_pkg::OFS_STATUS, status_word(3'h0, 2'h3), "cause_pin");
        rd(pmm_pkg::OFS_RETEN, 32'hf, "shdn_lost");
        wr(pmm_pkg::OFS_WAKEMASK, 32'h20);
        wr(pmm_pkg::OFS_CTRL, 32'h4);
        settle(2);
        chk("hold", {30'h0, pwr_out.io_latch, pwr_out.por_en}, 32'h2);
        @(posedge mclk_in);
        rtc_wake_in <= 1'h1;
        io_in[5] <= 1'h0;
        @(posedge mclk_in);
        rtc_wake_in <= 1'h0;
        settle(8);
        chk("hold_stay", {31'h0, pwr_out.cpu_clk_en}, 32'h0);
        @(posedge mclk_in);
        reset_pin_n_in <= 1'h0;
        wake_time(41, 48, 3'h1, "pin_wake");
        rd(pmm_pkg::OFS_STATUS, status_word(3'h0, 2'h2), "cause_rst");
        // a fresh power-on reset must replace the pin cause
        @(posedge mclk_in);
        nrst_in <= 1'h0;
        repeat (2) @(posedge mclk_in);
        nrst_in <= 1'h1;
        @(posedge mclk_in);
        rd(pmm_pkg::OFS_STATUS, status_word(3'h0, 2'h1), "status_por2");
        end_sim();
    end

    initial begin
        #500000;
        errors++;
        end_sim();
    end
endmodule
